// [logic/mdsl_pkg.sv]
// Package of constants and types shared by both ends of the channel loader
// What this block does
// RQ1: One word is 19 bits: address, code.
// RQ2: Five address bits select one of 32, MSB first.
// RQ3: Code goes only to the addressed channel.
// RQ4: Data held stable, sampled at falling shift edge.
// RQ5: Frame-sync falling edge clears the bit counter; the code clears it only when no word is in progress.
// RQ6: Frame-sync ignored until 19 bits arrive.
// RQ7: Extra shift edges ignored after 19 bits.
// RQ8: Host starts each write with new frame-sync fall.
// RQ9: Host waits at least 200 ns between writes.
// RQ10: Works with continuous or gated shift clock.
// RQ11: Host shift clock no faster than 30 MHz.
// RQ12: Frame-sync high means no register changes.
// RQ13: All channel registers are zero at power-on.
// RQ14: Reset low clears every register to zero.
// RQ15: Codes are straight binary, 0 to 16383.
// RQ16: Channel loads on final bit, no strobe.
// RQ17: Shift only while frame-sync is low.
// RQ18: Send MSB first: address then code.
// RQ19: Short word updates no channel register; the code keeps the count, so the next frame ends it and loads a channel.
package mdsl_pkg;
  localparam int ADDR_W = 5;
  localparam int CODE_W = 14;
  localparam int WORD_W = ADDR_W + CODE_W;
  localparam int NUM_CH = 32;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h13;
  localparam logic [CODE_W-1:0] CODE_RST = 14'h0000;
  localparam int CLK_MHZ = 200;
  localparam int SCLK_MAX_MHZ = 30;
  localparam int GAP_NS = 200;
  localparam int CLK_NS = 5;
  // Half period of the made shift clock, rounded up so 30 MHz is never passed
  localparam int SCLK_HALF_CYC =
    (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  typedef logic [CODE_W-1:0] mdsl_code_t;
  typedef logic [WORD_W-1:0] mdsl_word_t;
endpackage : mdsl_pkg

// [logic/mdsl_link_if.sv]
// Serial link between host and channel loader: three serial wires plus a reset line
`timescale 1ns/1ps
interface mdsl_link_if;
  logic sync_n;
  logic sclk;
  logic sdata;
  logic rst_n;
  modport host (output sync_n, output sclk, output sdata, output rst_n);
  modport device (input sync_n, input sclk, input sdata, input rst_n);
endinterface : mdsl_link_if

// [logic/mdsl_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module mdsl_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [PW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Occupancy gives honest full and empty
  assign in_ready = cnt_reg != (PW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];

  ////////////////////////////////////////////////////////////////////////
  // Pointers and count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage, no reset needed since reads gate on the count
  always_ff @(posedge mclk) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end
endmodule : mdsl_fifo

// [logic/mdsl_host.sv]
// Host end: queues words and serialises them onto the link
`timescale 1ns/1ps
module mdsl_host (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [mdsl_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [mdsl_pkg::CODE_W-1:0] wr_code,
  input wire logic dev_reset,
  output logic busy,
  mdsl_link_if.host link
);
  import mdsl_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SHIFT = 2'b01,
    HS_GAP = 2'b11
  } mdsl_hstate_e;

  mdsl_hstate_e st_reg;
  mdsl_word_t sh_reg;
  logic [CNT_W-1:0] bit_reg;
  logic [7:0] div_reg;
  logic sclk_reg;
  logic sync_n_reg;
  logic rstn_reg;
  logic f_valid;
  logic f_ready;
  mdsl_word_t f_data;

  // Queue keeps the requester going while a word is on the wire
  mdsl_fifo #(.WIDTH(WORD_W), .DEPTH(4)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_addr, wr_code}), // see RQ1
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  wire half_tick = div_reg == 8'(SCLK_HALF_CYC - 1);
  wire last_bit = bit_reg == WORD_BITS - 5'h01;
  assign f_ready = st_reg == HS_IDLE;
  assign busy = st_reg != HS_IDLE || f_valid;
  assign link.sync_n = sync_n_reg;
  assign link.sclk = sclk_reg;
  assign link.sdata = sh_reg[WORD_W-1]; // see RQ18
  assign link.rst_n = rstn_reg;

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer; clock is gated, idling high between frames
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= HS_IDLE;
      sh_reg <= '0;
      bit_reg <= '0;
      div_reg <= '0;
      sclk_reg <= 1'b1;
      sync_n_reg <= 1'b1;
      rstn_reg <= 1'b0;
    end else begin
      rstn_reg <= !dev_reset;
      // Free count; the shift state wraps it each half period, and the gap
      // state needs it to run on past the half period to time the pause
      div_reg <= div_reg + 8'h01;
      case (st_reg)
        HS_IDLE: begin
          div_reg <= '0;
          if (f_valid) begin
            sh_reg <= f_data;
            bit_reg <= '0;
            sync_n_reg <= 1'b0; // see RQ8
            st_reg <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          if (half_tick) begin
            sclk_reg <= !sclk_reg;
            div_reg <= '0; // see RQ11
            // Shift after falling edge so data held across it, see RQ4
            if (!sclk_reg) begin
              sh_reg <= {sh_reg[WORD_W-2:0], 1'b0};
              bit_reg <= bit_reg + 5'h01;
            end
            if (!sclk_reg && last_bit) begin
              sync_n_reg <= 1'b1;
              st_reg <= HS_GAP;
              div_reg <= '0;
            end
          end
        end
        HS_GAP: begin
          // Wait out the idle gap between writes, see RQ9
          if (div_reg == 8'(GAP_CYC - 1)) st_reg <= HS_IDLE;
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end
endmodule : mdsl_host

// [logic/mdsl_device.sv]
// Device end: samples the link and loads the 32 channel registers
`timescale 1ns/1ps
module mdsl_device (
  input wire logic mclk,
  input wire logic sys_rst,
  mdsl_link_if.device link,
  output mdsl_pkg::mdsl_code_t ch_code [mdsl_pkg::NUM_CH],
  output logic load_pulse,
  output logic [mdsl_pkg::ADDR_W-1:0] load_addr
);
  import mdsl_pkg::*;

  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic sclk_d_reg;
  logic sync_d_reg;
  logic active_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [WORD_W-2:0] sh_reg;
  mdsl_code_t ch_reg [NUM_CH];
  logic load_reg;
  logic [ADDR_W-1:0] laddr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; link clock is sampled like any pin
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      // Idle link levels, so no false edge once reset lets go
      s1_reg <= 4'h6;
      s2_reg <= 4'h6;
    end else begin
      s1_reg <= {link.rst_n, link.sync_n, link.sclk, link.sdata};
      s2_reg <= s1_reg;
    end
  end

  wire rst_n_s = s2_reg[3];
  wire sync_n_s = s2_reg[2];
  wire sclk_s = s2_reg[1];
  wire din_s = s2_reg[0];
  wire sync_fall = sync_d_reg && !sync_n_s;
  wire sclk_fall = sclk_d_reg && !sclk_s; // see RQ10
  // Only falling shift edges inside a frame with sync low count, see RQ17
  wire take_bit = active_reg && sclk_fall && !sync_n_s; // see RQ12
  wire word_done = take_bit && cnt_reg == WORD_BITS - 5'h01; // see RQ1
  wire [ADDR_W-1:0] dec_addr = sh_reg[WORD_W-2 -: ADDR_W]; // see RQ2
  wire [CODE_W-1:0] dec_code = {sh_reg[CODE_W-2:0], din_s};

  assign ch_code = ch_reg;
  assign load_pulse = load_reg;
  assign load_addr = laddr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking and shifting; pin reset acts like power-on
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_reg <= 1'b1;
      sync_d_reg <= 1'b1;
      active_reg <= 1'b0;
      cnt_reg <= '0;
      sh_reg <= '0;
      load_reg <= 1'b0;
      laddr_reg <= '0;
    end else if (!rst_n_s) begin
      sclk_d_reg <= sclk_s; // see RQ14
      sync_d_reg <= sync_n_s;
      active_reg <= 1'b0;
      cnt_reg <= '0;
      sh_reg <= '0;
      load_reg <= 1'b0;
      laddr_reg <= '0;
    end else begin
      sclk_d_reg <= sclk_s;
      sync_d_reg <= sync_n_s;
      load_reg <= word_done;
      // Sync edges mid-word are ignored, see RQ6
      if (sync_fall && !active_reg) begin
        active_reg <= 1'b1;
        cnt_reg <= '0; // see RQ5
      end else if (take_bit) begin
        sh_reg <= {sh_reg[WORD_W-3:0], din_s}; // see RQ4 see RQ18
        cnt_reg <= cnt_reg + 5'h01;
        // After the last bit, clocks are ignored until rearmed, see RQ7
        if (word_done) active_reg <= 1'b0;
      end
      if (word_done) laddr_reg <= dec_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel registers: only the addressed one changes, on the final bit;
  // a short frame never reaches word_done so nothing loads
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) ch_reg[i] <= CODE_RST; // see RQ13
    end else if (!rst_n_s) begin
      for (int i = 0; i < NUM_CH; i++) ch_reg[i] <= CODE_RST; // see RQ14
    end else if (word_done) begin
      // Straight binary code stored as is, see RQ15
      ch_reg[dec_addr] <= dec_code; // see RQ3 see RQ16 see RQ19
    end
  end
endmodule : mdsl_device

// [test/mdsl_monitor.sv]
// Checker of the serial link between host and device
`timescale 1ns/1ps
module mdsl_monitor
  import mdsl_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic rst_n
);
  logic sclk_q_reg;
  logic [4:0] nbit_reg;
  logic [5:0] idle_reg;
  wire fall = sclk_q_reg & ~sclk;
  wire idle_max = &idle_reg;
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Falls in a frame; idle time saturates so long pauses do not wrap
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q_reg <= 1'b1;
      nbit_reg <= 5'h00;
      idle_reg <= 6'h3f;
    end else begin
      sclk_q_reg <= sclk;
      nbit_reg <= sync_n ? 5'h00 : nbit_reg + {4'h0, fall};
      idle_reg <= sync_n ? idle_reg + {5'h00, ~idle_max} : 6'h00;
    end
  end
  ////////////////////////////////////////
  sequence low_hold;
    !sclk [*4];
  endsequence
  sequence high_hold;
    sclk [*4];
  endsequence
  data_hold_a:
    assert property (fall |-> $stable(sdata))
    else $error("data moved at shift edge");
  frame_bits_a:
    assert property ($rose(sync_n) |-> nbit_reg == WORD_BITS)
    else $error("wrong frame length");
  bit_cap_a:
    assert property (nbit_reg <= WORD_BITS)
    else $error("too many shift edges");
  idle_quiet_a:
    assert property (sync_n && $past(sync_n) |-> !fall)
    else $error("shift edge outside frame");
  frame_start_a:
    assert property ($fell(sync_n) |-> sclk && nbit_reg == 5'h00)
    else $error("frame opened badly");
  low_time_a:
    assert property (fall |-> low_hold)
    else $error("shift clock low too short");
  high_time_a:
    assert property ($rose(sclk) && !sync_n |-> high_hold)
    else $error("shift clock high too short");
  gap_time_a:
    assert property ($fell(sync_n) |-> idle_reg >= GAP_CYC)
    else $error("gap between words too short");
endmodule : mdsl_monitor

// [test/multichannel_dac_serial_loader_tb.sv]
// Bench for the host and device ends of the channel loader
`timescale 1ns/1ps
module multichannel_dac_serial_loader_tb;
  import mdsl_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_valid = 1'b0;
  logic dev_reset = 1'b0;
  logic full_seen = 1'b0;
  logic [ADDR_W-1:0] last_addr = 5'h00;
  logic [ADDR_W-1:0] wr_addr = 5'h00;
  mdsl_code_t wr_code = 14'h0000;
  logic wr_ready, busy, load_pulse;
  logic [ADDR_W-1:0] load_addr;
  mdsl_code_t ch_code [NUM_CH], ch2 [NUM_CH], want [NUM_CH], want2 [NUM_CH];
  int fails = 0, cmp_count = 0, loads = 0, puts = 0;
  mdsl_link_if link ();
  mdsl_link_if bad ();
  always #2.5 mclk = ~mclk;
  mdsl_host mdsl_host_inst (.mclk(mclk), .sys_rst(sys_rst),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_code(wr_code), .dev_reset(dev_reset), .busy(busy), .link(link));
  mdsl_device mdsl_device_inst (.mclk(mclk), .sys_rst(sys_rst),
    .link(link), .ch_code(ch_code), .load_pulse(load_pulse),
    .load_addr(load_addr));
  // Second device, fed by the bench so framing can be broken
  mdsl_device mdsl_device_inst2 (.mclk(mclk), .sys_rst(sys_rst),
    .link(bad), .ch_code(ch2), .load_pulse(), .load_addr());
  mdsl_monitor mdsl_monitor_inst (.mclk(mclk), .sys_rst(sys_rst),
    .sync_n(link.sync_n), .sclk(link.sclk), .sdata(link.sdata),
    .rst_n(link.rst_n));
  ////////////////////////////////////////
  // Refusals and loads, sampled away from the driving edge
  always @(negedge mclk) begin
    if (wr_valid && wr_ready === 1'b0) full_seen <= 1'b1;
    if (load_pulse === 1'b1) loads++;
    if (load_pulse === 1'b1) last_addr <= load_addr;
  end
  task automatic check(input mdsl_code_t got, input mdsl_code_t exp_v);
    cmp_count++;
    if (got !== exp_v) begin
      fails++;
      $display("unexpected at %0t got %h want %h", $time, got, exp_v);
    end
  endtask : check
  // Offer one word and hold it until the queue takes it
  task automatic put(input logic [ADDR_W-1:0] a, input mdsl_code_t c);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_code <= c;
    want[a] = c;
    puts++;
    @(negedge mclk);
    while (wr_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
  endtask : put
  // Let the queue empty, then compare every channel
  task automatic drain;
    wr_valid <= 1'b0;
    repeat (4) @(negedge mclk);
    while (busy !== 1'b0) @(negedge mclk);
    repeat (8) @(negedge mclk);
    foreach (ch_code[i]) check(ch_code[i], want[i]);
    @(posedge mclk);
  endtask : drain
  // One bit per 160 ns (32 cycles), data set while the shift clock is high
  task automatic bits(input mdsl_word_t w, input int n);
    repeat (n) begin
      bad.sdata <= w[WORD_W-1]; // Top bit first
      w = w << 1;
      repeat (8) @(posedge mclk);
      bad.sclk <= 1'b0; // Sampling edge
      repeat (16) @(posedge mclk);
      bad.sclk <= 1'b1;
      repeat (8) @(posedge mclk);
    end
  endtask : bits
  task automatic frame(input mdsl_word_t w, input int n, input bit glitch);
    bad.sync_n <= 1'b0; // Opens the word
    repeat (16) @(posedge mclk);
    bits(w, 8);
    if (glitch) begin
      bad.sync_n <= 1'b1;
      repeat (8) @(posedge mclk);
      bad.sync_n <= 1'b0;
    end
    bits(w << 8, n - 8);
    repeat (16) @(posedge mclk);
    bad.sync_n <= 1'b1;
    bad.sdata <= ~bad.sdata;
    repeat (80) @(posedge mclk); // Pause well over the minimum
  endtask : frame
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  // Watchdog set well past the expected run of about 48 us
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
  initial begin
    bad.sync_n = 1'b1;
    bad.sclk = 1'b1;
    bad.sdata = 1'b0;
    bad.rst_n = 1'b0;
    foreach (want[i]) want[i] = 14'h0000;
    want2 = want;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    bad.rst_n <= 1'b1;
    @(posedge mclk);
    drain();
    for (int i = 0; i < NUM_CH; i++) begin
      put(5'(i), 14'h3fff - 14'(i * 515));
    end
    drain();
    check(14'(last_addr), 14'h001f);
    check(14'(loads), 14'(puts));
    check(14'(full_seen), 14'h0001);
    put(5'h11, 14'h0001);
    put(5'h00, 14'h0000);
    drain();
    dev_reset <= 1'b1;
    repeat (30) @(posedge mclk);
    dev_reset <= 1'b0;
    foreach (want[i]) want[i] = 14'h0000;
    drain();
    frame({5'h05, 14'h2aaa}, 19, 1'b0);
    frame({5'h06, 14'h1555}, 19, 1'b1);
    frame({5'h07, 14'h3fff}, 22, 1'b0);
    want2[5] = 14'h2aaa;
    want2[6] = 14'h1555;
    want2[7] = 14'h3fff;
    // Shift and data activity while the frame line is high
    repeat (6) begin
      repeat (16) @(posedge mclk);
      bad.sclk <= ~bad.sclk;
      bad.sdata <= ~bad.sdata;
    end
    frame({5'h08, 14'h0abc}, 12, 1'b0);
    @(negedge mclk);
    foreach (ch2[i]) check(ch2[i], want2[i]);
    @(posedge mclk);
    bad.rst_n <= 1'b0;
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    foreach (ch2[i]) check(ch2[i], 14'h0000);
    report_and_stop();
  end
endmodule : multichannel_dac_serial_loader_tb
